/* File: design/ctu_pkg.sv */
// package: register map and field layout of the charge/time edge control block
package ctu_pkg;
	// register byte addresses
	localparam logic [3:0] ADDR_CTRL_ONE = 4'h0;
	localparam logic [3:0] ADDR_CTRL_TWO = 4'h4;
	localparam logic [3:0] ADDR_CUR_CTRL = 4'h8;
	localparam logic [3:0] ADDR_FLAGS = 4'hC;
	// measure_control_one fields
	localparam int ONE_MODULE_ON = 15;
	localparam int ONE_IDLE_HALT = 13;
	localparam int ONE_DELAY_MODE = 12;
	localparam int ONE_EDGE_PASS = 11;
	localparam int ONE_SEQ_ENFORCE = 10;
	localparam int ONE_DISCHARGE = 9;
	localparam int ONE_CONV_TRIG = 8;
	localparam logic [15:0] ONE_WMASK = 16'hBF00;
	// measure_control_two fields
	localparam int TWO_FIRST_POL = 14;
	localparam int TWO_FIRST_SEL_LO = 10;
	localparam int TWO_SECOND_SEEN = 9;
	localparam int TWO_FIRST_SEEN = 8;
	localparam int TWO_SECOND_POL = 6;
	localparam int TWO_SECOND_SEL_LO = 2;
	localparam logic [15:0] TWO_WMASK = 16'h7F7C;
	// current_source_control fields
	localparam int CUR_TRIM_LO = 10;
	localparam int CUR_RANGE_LO = 8;
	localparam logic [15:0] CUR_WMASK = 16'hFF00;
	// flag register: interrupt flag and its enable
	localparam int FLG_IRQ_FLAG = 13;
	localparam int FLG_IRQ_EN = 12;
	// reset values
	localparam logic [15:0] RST_REG = 16'h0000;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

/* File: design/ctu_top.sv */
// top: charge/time edge control with axi4-lite register slave
//
// Summary of operation
// - two-bit current range at bits 9:8
// - six-bit trim at bits 15:10
// - channels respond to level, not transitions
// - per-channel four-bit source select
// - per-channel polarity, low-active after reset
// - sequence mode: second only after first
// - event sets the channel status bit
// - config change at active level sets status
// - current on only with exactly one status
// - software writes status bits directly
// - flag set on every current transition
// - request only when flag and enable set
// - converter trigger after second event when enabled
// - mode bit selects measure or delay
// - edge pass bit gates events
// - idle halt stops edge detection in idle; current output keeps following status
// - polarity one high-active, zero low-active
// - discharge bit grounds the current output
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ctu_top #(
	parameter int SRC_N = 16
) (
	// clock and reset
	input wire logic CLK_SYS_IN,
	input wire logic RST_N_IN,
	// axi4-lite write address
	input wire logic S_AXI_AWVALID_IN,
	output logic S_AXI_AWREADY_OUT,
	input wire logic [3:0] S_AXI_AWADDR_IN,
	// axi4-lite write data
	input wire logic S_AXI_WVALID_IN,
	output logic S_AXI_WREADY_OUT,
	input wire logic [31:0] S_AXI_WDATA_IN,
	input wire logic [3:0] S_AXI_WSTRB_IN,
	// axi4-lite write response
	output logic S_AXI_BVALID_OUT,
	input wire logic S_AXI_BREADY_IN,
	output logic [1:0] S_AXI_BRESP_OUT,
	// axi4-lite read
	input wire logic S_AXI_ARVALID_IN,
	output logic S_AXI_ARREADY_OUT,
	input wire logic [3:0] S_AXI_ARADDR_IN,
	output logic S_AXI_RVALID_OUT,
	input wire logic S_AXI_RREADY_IN,
	output logic [31:0] S_AXI_RDATA_OUT,
	output logic [1:0] S_AXI_RRESP_OUT,
	// edge sources, asynchronous
	input wire logic [SRC_N-1:0] EDGE_SRC_IN,
	input wire logic CHIP_IDLE_IN,
	// analog side
	output logic CURRENT_ON_OUT,
	output logic DISCHARGE_GROUND_OUT,
	output logic DELAY_MODE_OUT,
	output logic [1:0] CURRENT_RANGE_OUT,
	output logic [5:0] CURRENT_TRIM_OUT,
	output logic CONV_TRIGGER_OUT,
	output logic IRQ_OUT
);
	typedef struct packed {
		logic [SRC_N-1:0] sync1;
		logic [SRC_N-1:0] sync2;
		logic idle1;
		logic idle2;
		logic [15:0] ctrl_one;
		logic [15:0] ctrl_two;
		logic [15:0] cur_ctrl;
		logic irq_flag;
		logic irq_en;
		logic cur_on;
		logic trig;
		logic aw_held;
		logic [3:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ctu_state_t;

	ctu_state_t s_q;
	ctu_state_t s_d;

	logic first_lvl;
	logic second_lvl;
	logic first_hit;
	logic second_hit;
	logic running;
	logic do_write;
	logic do_read;
	logic [15:0] wmask16;
	logic [15:0] rd16;
	logic rd_ok;
	logic wr_ok;
	logic cur_next;

	// level compare against polarity; no edge detection on purpose
	always_comb
	begin
		first_lvl = s_q.sync2[s_q.ctrl_two[ctu_pkg::TWO_FIRST_SEL_LO +: 4]];
		second_lvl = s_q.sync2[s_q.ctrl_two[ctu_pkg::TWO_SECOND_SEL_LO +: 4]];
		first_lvl = (first_lvl == s_q.ctrl_two[ctu_pkg::TWO_FIRST_POL]);
		second_lvl = (second_lvl == s_q.ctrl_two[ctu_pkg::TWO_SECOND_POL]);
	end

	// idle halt freezes the edge logic while the chip idles
	assign running = s_q.ctrl_one[ctu_pkg::ONE_MODULE_ON]
		& ~(s_q.ctrl_one[ctu_pkg::ONE_IDLE_HALT] & s_q.idle2);
	assign first_hit = running & s_q.ctrl_one[ctu_pkg::ONE_EDGE_PASS] & first_lvl;
	assign second_hit = running & s_q.ctrl_one[ctu_pkg::ONE_EDGE_PASS] & second_lvl
		& (~s_q.ctrl_one[ctu_pkg::ONE_SEQ_ENFORCE]
		| s_q.ctrl_two[ctu_pkg::TWO_FIRST_SEEN]);

	assign do_write = s_q.aw_held & s_q.w_held & ~s_q.bvalid;
	assign do_read = S_AXI_ARVALID_IN & ~s_q.rvalid;
	assign wmask16 = {{8{s_q.w_strb[1]}}, {8{s_q.w_strb[0]}}};
	assign wr_ok = (s_q.aw_addr == ctu_pkg::ADDR_CTRL_ONE) | (s_q.aw_addr == ctu_pkg::ADDR_CTRL_TWO)
		| (s_q.aw_addr == ctu_pkg::ADDR_CUR_CTRL) | (s_q.aw_addr == ctu_pkg::ADDR_FLAGS);

	always_comb
	begin
		rd_ok = 1'b1;
		rd16 = 16'h0000;
		unique case (S_AXI_ARADDR_IN)
			ctu_pkg::ADDR_CTRL_ONE: rd16 = s_q.ctrl_one;
			ctu_pkg::ADDR_CTRL_TWO: rd16 = s_q.ctrl_two;
			ctu_pkg::ADDR_CUR_CTRL: rd16 = s_q.cur_ctrl;
			ctu_pkg::ADDR_FLAGS:
				rd16 = 16'(({15'h0000, s_q.irq_flag} << ctu_pkg::FLG_IRQ_FLAG)
					| ({15'h0000, s_q.irq_en} << ctu_pkg::FLG_IRQ_EN));
			default: rd_ok = 1'b0;
		endcase
	end

	always_comb
	begin
		s_d = s_q;
		s_d.sync1 = EDGE_SRC_IN;
		s_d.sync2 = s_q.sync1;
		s_d.idle1 = CHIP_IDLE_IN;
		s_d.idle2 = s_q.idle1;
		// write channel capture, either order
		if (S_AXI_AWVALID_IN && !s_q.aw_held)
		begin
			s_d.aw_held = 1'b1;
			s_d.aw_addr = S_AXI_AWADDR_IN;
		end
		if (S_AXI_WVALID_IN && !s_q.w_held)
		begin
			s_d.w_held = 1'b1;
			s_d.w_data = S_AXI_WDATA_IN;
			s_d.w_strb = S_AXI_WSTRB_IN;
		end
		if (do_write)
		begin
			s_d.aw_held = 1'b0;
			s_d.w_held = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = wr_ok ? ctu_pkg::RESP_OKAY : ctu_pkg::RESP_DECERR;
			unique case (s_q.aw_addr)
				ctu_pkg::ADDR_CTRL_ONE:
					s_d.ctrl_one = (s_q.ctrl_one & ~(wmask16 & ctu_pkg::ONE_WMASK))
						| (s_q.w_data[15:0] & wmask16 & ctu_pkg::ONE_WMASK);
				ctu_pkg::ADDR_CTRL_TWO:
					s_d.ctrl_two = (s_q.ctrl_two & ~(wmask16 & ctu_pkg::TWO_WMASK))
						| (s_q.w_data[15:0] & wmask16 & ctu_pkg::TWO_WMASK);
				ctu_pkg::ADDR_CUR_CTRL:
					s_d.cur_ctrl = (s_q.cur_ctrl & ~(wmask16 & ctu_pkg::CUR_WMASK))
						| (s_q.w_data[15:0] & wmask16 & ctu_pkg::CUR_WMASK);
				ctu_pkg::ADDR_FLAGS:
					if (s_q.w_strb[1])
					begin
						s_d.irq_flag = s_q.w_data[ctu_pkg::FLG_IRQ_FLAG];
						s_d.irq_en = s_q.w_data[ctu_pkg::FLG_IRQ_EN];
					end
				default: ;
			endcase
		end
		if (s_q.bvalid && S_AXI_BREADY_IN)
			s_d.bvalid = 1'b0;
		if (do_read)
		begin
			s_d.rvalid = 1'b1;
			s_d.rdata = {16'h0000, rd16};
			s_d.rresp = rd_ok ? ctu_pkg::RESP_OKAY : ctu_pkg::RESP_DECERR;
		end
		else if (s_q.rvalid && S_AXI_RREADY_IN)
			s_d.rvalid = 1'b0;
		// hardware set wins over a same-cycle software clear
		if (first_hit)
			s_d.ctrl_two[ctu_pkg::TWO_FIRST_SEEN] = 1'b1;
		if (second_hit)
			s_d.ctrl_two[ctu_pkg::TWO_SECOND_SEEN] = 1'b1;
		// current follows the registered status bits
		cur_next = s_q.ctrl_one[ctu_pkg::ONE_MODULE_ON]
			& (s_q.ctrl_two[ctu_pkg::TWO_FIRST_SEEN] ^ s_q.ctrl_two[ctu_pkg::TWO_SECOND_SEEN]);
		s_d.cur_on = cur_next;
		if (cur_next != s_q.cur_on)
			s_d.irq_flag = 1'b1;
		s_d.trig = second_hit & ~s_q.ctrl_two[ctu_pkg::TWO_SECOND_SEEN]
			& s_q.ctrl_one[ctu_pkg::ONE_CONV_TRIG];
	end

	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign S_AXI_AWREADY_OUT = ~s_q.aw_held;
	assign S_AXI_WREADY_OUT = ~s_q.w_held;
	assign S_AXI_BVALID_OUT = s_q.bvalid;
	assign S_AXI_BRESP_OUT = s_q.bresp;
	assign S_AXI_ARREADY_OUT = ~s_q.rvalid;
	assign S_AXI_RVALID_OUT = s_q.rvalid;
	assign S_AXI_RDATA_OUT = s_q.rdata;
	assign S_AXI_RRESP_OUT = s_q.rresp;
	assign CURRENT_ON_OUT = s_q.cur_on;
	assign DISCHARGE_GROUND_OUT = s_q.ctrl_one[ctu_pkg::ONE_DISCHARGE];
	assign DELAY_MODE_OUT = s_q.ctrl_one[ctu_pkg::ONE_DELAY_MODE];
	assign CURRENT_RANGE_OUT = s_q.cur_ctrl[ctu_pkg::CUR_RANGE_LO +: 2];
	assign CURRENT_TRIM_OUT = s_q.cur_ctrl[ctu_pkg::CUR_TRIM_LO +: 6];
	assign CONV_TRIGGER_OUT = s_q.trig;
	assign IRQ_OUT = s_q.irq_flag & s_q.irq_en;

	a_current_xor: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		1'b1 |=> CURRENT_ON_OUT == ($past(s_q.ctrl_one[ctu_pkg::ONE_MODULE_ON])
		& ($past(s_q.ctrl_two[9]) ^ $past(s_q.ctrl_two[8]))))
		else $error("current not exactly-one status");
	a_flag_on_toggle: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		$changed(CURRENT_ON_OUT) |-> s_q.irq_flag)
		else $error("no flag on current change");
	a_irq_gate: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		IRQ_OUT |-> (s_q.irq_flag && s_q.irq_en))
		else $error("irq without flag and enable");
	a_seq_order: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		(s_q.ctrl_one[ctu_pkg::ONE_SEQ_ENFORCE] && !s_q.ctrl_two[8] && !s_q.ctrl_two[9]
		&& !do_write) |=> !s_q.ctrl_two[9])
		else $error("second event before first");
	a_edge_block: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		(!s_q.ctrl_one[ctu_pkg::ONE_EDGE_PASS] && !do_write && !s_q.ctrl_two[8])
		|=> !s_q.ctrl_two[8])
		else $error("blocked edge set status");
	a_off_no_current: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		!s_q.ctrl_one[ctu_pkg::ONE_MODULE_ON] |=> !CURRENT_ON_OUT)
		else $error("current on while module off");
	a_level_sets: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		first_hit |=> s_q.ctrl_two[8])
		else $error("active level did not set status");
	a_trig_gate: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		CONV_TRIGGER_OUT |-> $past(s_q.ctrl_one[ctu_pkg::ONE_CONV_TRIG]) && s_q.ctrl_two[9])
		else $error("trigger without enable or second event");
	a_idle_halt: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		(s_q.idle2 && s_q.ctrl_one[ctu_pkg::ONE_IDLE_HALT]) |-> !first_hit && !second_hit)
		else $error("edges taken while halted in idle");

	// bus answers stand until the master takes them
	a_bvalid_hold: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT)
		else $error("write response dropped early");

	a_bresp_hold: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> $stable(S_AXI_BRESP_OUT))
		else $error("write response changed while waiting");

	a_rvalid_hold: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=> S_AXI_RVALID_OUT)
		else $error("read response dropped early");

	a_rdata_hold: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=> $stable(S_AXI_RDATA_OUT))
		else $error("read data changed while waiting");

	a_rdata_upper: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		S_AXI_RVALID_OUT |-> S_AXI_RDATA_OUT[31:16] == 16'h0000)
		else $error("upper read half not zero");

	// unmapped writes are refused with an error and change nothing
	a_decerr_wr: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		do_write && !wr_ok |=> S_AXI_BRESP_OUT == ctu_pkg::RESP_DECERR)
		else $error("unmapped write not refused");

	a_okay_wr: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		do_write && wr_ok |=> S_AXI_BRESP_OUT == ctu_pkg::RESP_OKAY)
		else $error("mapped write not accepted");

	// status bits: hardware sets, software writes, both stick
	a_second_sets: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		second_hit |=> s_q.ctrl_two[9])
		else $error("second level did not set status");

	a_status_sticky: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		s_q.ctrl_two[8] && !do_write |=> s_q.ctrl_two[8])
		else $error("status cleared without a write");

	a_status_write: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		do_write && s_q.aw_addr == ctu_pkg::ADDR_CTRL_TWO && s_q.w_strb[1] && !first_hit
		|=> s_q.ctrl_two[8] == $past(s_q.w_data[8]))
		else $error("software status write lost");

	a_off_frozen: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		!running && !do_write && !s_q.ctrl_two[8] |=> !s_q.ctrl_two[8])
		else $error("status set while module stopped");

	a_both_off: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		s_q.ctrl_two[8] && s_q.ctrl_two[9] |=> !CURRENT_ON_OUT)
		else $error("current on with both status set");

	a_none_off: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		!s_q.ctrl_two[8] && !s_q.ctrl_two[9] |=> !CURRENT_ON_OUT)
		else $error("current on with no status set");

	// flag, trigger and request
	a_flag_sticky: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		s_q.irq_flag && !do_write |=> s_q.irq_flag)
		else $error("flag cleared without a write");

	a_trig_pulse: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		CONV_TRIGGER_OUT |=> !CONV_TRIGGER_OUT)
		else $error("trigger longer than one cycle");

	a_trig_off: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		!s_q.ctrl_one[ctu_pkg::ONE_CONV_TRIG] |=> !CONV_TRIGGER_OUT)
		else $error("trigger while disabled");

	a_irq_en_low: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		!s_q.irq_en |-> !IRQ_OUT)
		else $error("request while disabled");

	// unused register bits never come up
	a_one_unused: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		(s_q.ctrl_one & ~ctu_pkg::ONE_WMASK) == 16'h0000)
		else $error("unused control one bit set");

	a_two_unused: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		(s_q.ctrl_two & 16'h8083) == 16'h0000)
		else $error("unused control two bit set");

	// analog settings follow the last write
	a_mode_write: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		do_write && s_q.aw_addr == ctu_pkg::ADDR_CTRL_ONE && s_q.w_strb[1]
		|=> DELAY_MODE_OUT == $past(s_q.w_data[12]))
		else $error("mode bit not written");

	a_range_write: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		do_write && s_q.aw_addr == ctu_pkg::ADDR_CUR_CTRL && s_q.w_strb[1]
		|=> CURRENT_RANGE_OUT == $past(s_q.w_data[9:8]))
		else $error("range field not written");
endmodule
`default_nettype wire

/* File: sim/ctu_src_model.sv */
// edge source model: presents the source levels that the bench asks for
`timescale 1ns/1ps
`default_nettype none
module ctu_src_model (
	// clock
	input wire logic clk_in,
	// requested levels
	input wire logic [15:0] lvl_in,
	// source levels to the block
	output logic [15:0] src_out
);
	// sources hold a level, not a pulse, so the block sees a steady state
	always_ff @(posedge clk_in)
	begin
		src_out <= lvl_in;
	end
endmodule
`default_nettype wire

/* File: sim/charge_time_edge_control_test.sv */
// testbench: register bus, edge events, current source, trigger and irq checks
`timescale 1ns/1ps
`default_nettype none
module charge_time_edge_control_test;
	logic clk = 0, rst_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, idle = 0;
	logic [3:0] awa = 4'h0, ara = 4'h0;
	logic [31:0] wd = 32'h0, rd, got;
	logic [15:0] lvl = 16'h0, src;
	logic awr, wr, bv, arr, rv, con, dis, dly, trg, irq;
	logic [1:0] br, rr, rng, resp;
	logic [5:0] trm;
	int errors = 0, tests_run = 0, trig_n = 0;
	logic [3:0] row_a [7] = '{4'h8, 4'h8, 4'h4, 4'h0, 4'hC, 4'hC, 4'h0};
	logic [31:0] row_w [7] = '{32'hFFFF, 32'h8100, 32'hFFFFFCFF, 32'hFFFFFFFF,
		32'hFFFF, 32'h0, 32'h0};
	logic [31:0] row_r [7] = '{32'hFF00, 32'h8100, 32'h7C7C, 32'hBF00, 32'h3000, 32'h0, 32'h0};
	logic [10:0] row_o [7] = '{11'h7F8, 11'h408, 11'h408, 11'h40E, 11'h40F, 11'h40E, 11'h408};
	always #4 clk = ~clk;
	always @(negedge clk) if (trg === 1'b1) trig_n++;
	ctu_src_model i_src (.clk_in(clk), .lvl_in(lvl), .src_out(src));
	ctu_top i_dut (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .S_AXI_AWVALID_IN(awv),
		.S_AXI_AWREADY_OUT(awr), .S_AXI_AWADDR_IN(awa), .S_AXI_WVALID_IN(wv),
		.S_AXI_WREADY_OUT(wr), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hF),
		.S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bry), .S_AXI_BRESP_OUT(br),
		.S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr), .S_AXI_ARADDR_IN(ara),
		.S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rry), .S_AXI_RDATA_OUT(rd),
		.S_AXI_RRESP_OUT(rr), .EDGE_SRC_IN(src), .CHIP_IDLE_IN(idle), .CURRENT_ON_OUT(con),
		.DISCHARGE_GROUND_OUT(dis), .DELAY_MODE_OUT(dly), .CURRENT_RANGE_OUT(rng),
		.CURRENT_TRIM_OUT(trm), .CONV_TRIGGER_OUT(trg), .IRQ_OUT(irq));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// write: address and data offered together, each dropped when taken
	task automatic wrr(input logic [3:0] a, input logic [31:0] d);
		logic ah, wh, bh;
		int n;
		@(posedge clk);
		awv <= 1'b1;
		wv <= 1'b1;
		awa <= a;
		wd <= d;
		bry <= 1'b1;
		bh = 1'b0;
		n = 0;
		while (!bh && n < 50)
		begin
			@(negedge clk);
			ah = awv && awr;
			wh = wv && wr;
			bh = bv && bry;
			resp = br;
			@(posedge clk);
			if (ah)
				awv <= 1'b0;
			if (wh)
				wv <= 1'b0;
			n++;
		end
		bry <= 1'b0;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [31:0] e);
		logic ah, rh;
		int n;
		@(posedge clk);
		arv <= 1'b1;
		ara <= a;
		rry <= 1'b1;
		rh = 1'b0;
		n = 0;
		while (!rh && n < 50)
		begin
			@(negedge clk);
			ah = arv && arr;
			rh = rv && rry;
			got = rd;
			@(posedge clk);
			if (ah)
				arv <= 1'b0;
			n++;
		end
		rry <= 1'b0;
		chk("register", e, got);
	endtask
	// status follows sync delay plus one, current one more
	task automatic settle;
		repeat (6) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		#200000;
		errors++;
		final_report;
	end
	initial
	begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 4; i++)
			rchk(4'(i * 4), 32'h0);
		$display("test reset done");
		for (int i = 0; i < 7; i++)
		begin
			wrr(row_a[i], row_w[i]);
			chk("bresp", 32'(ctu_pkg::RESP_OKAY), 32'(resp));
			rchk(row_a[i], row_r[i]);
			@(negedge clk);
			chk("outputs", 32'(row_o[i]), 32'({trm, rng, dis, dly, irq}));
		end
		$display("test rows done");
		wrr(4'h4, 32'h4448);
		wrr(4'h0, 32'h8900);
		lvl <= 16'h0002;
		settle;
		chk("current", 32'h1, 32'(con));
		rchk(4'h4, 32'h4548);
		rchk(4'hC, 32'h2000);
		lvl <= 16'h0006;
		settle;
		chk("current", 32'h0, 32'(con));
		chk("trigger", 32'h1, 32'(trig_n));
		$display("test events done");
		lvl <= 16'h0;
		wrr(4'h4, 32'h4448);
		settle;
		chk("current", 32'h0, 32'(con));
		wrr(4'h4, 32'h4548);
		settle;
		chk("current", 32'h1, 32'(con));
		wrr(4'h4, 32'h4748);
		settle;
		chk("current", 32'h0, 32'(con));
		wrr(4'h4, 32'h0448);
		settle;
		rchk(4'h4, 32'h0548);
		wrr(4'h4, 32'h4448);
		// the old low polarity still sets status during that write, so clear again
		wrr(4'h4, 32'h4448);
		rchk(4'h4, 32'h4448);
		$display("test software done");
		wrr(4'h0, 32'h8C00);
		lvl <= 16'h0004;
		settle;
		rchk(4'h4, 32'h4448);
		lvl <= 16'h0006;
		settle;
		rchk(4'h4, 32'h4748);
		wrr(4'h0, 32'h0800);
		wrr(4'h4, 32'h4448);
		settle;
		rchk(4'h4, 32'h4448);
		chk("current", 32'h0, 32'(con));
		wrr(4'h0, 32'h8000);
		settle;
		rchk(4'h4, 32'h4448);
		idle <= 1'b1;
		wrr(4'h0, 32'hA800);
		settle;
		rchk(4'h4, 32'h4448);
		idle <= 1'b0;
		settle;
		rchk(4'h4, 32'h4748);
		$display("test gating done");
		wrr(4'hC, 32'h2000);
		@(negedge clk);
		chk("irq", 32'h0, 32'(irq));
		wrr(4'hC, 32'h3000);
		@(negedge clk);
		chk("irq", 32'h1, 32'(irq));
		$display("test irq done");
		final_report;
	end
endmodule
`default_nettype wire
